// File: design/fspc_consts.vh
/*
 Constants for the flash self-programming control and lock block:
 register offsets, control field positions, command patterns, reset
 values and programming times.
 Assumes a 20 MHz system clock and a 32-bit APB register port.
*/
// Overview of operation
// - Ready interrupt while enabled, global enable, idle
// - Live-section busy set by live erase/write
// - Busy cleared by re-enable or buffer load
// - Signature arm: load returns signature, store ignored
// - Re-enable live section only when idle
// - Re-enable during fill discards buffer contents
// - Lock-set store programs boot lock bits
// - Lock-set bit clears on completion or timeout
// - Load after lock-set returns lock or fuse
// - Page write stores buffer to pointer page
// - Page write bit clears on completion or timeout
// - Stall CPU for halting-section erase/write
// - Page erase of pointer page, self-clearing
// - Enable alone loads buffer word from pair
// - Enable clears on store/timeout, held during operation
// - Only listed five-bit patterns take effect
// - Six lock bits, only chip erase restores
// - Memory lock modes restrict external programming
// - Application lock modes restrict store/load
// - Boot lock modes restrict store/load
// - Page number from pointer bits 16..8
// - Buffer word from pointer bits 7..1
// - Erase/write/lock-set lasts 3.7 to 4.5 ms
`ifndef FSPC_CONSTS_VH
`define FSPC_CONSTS_VH

// ==========================================================
// Register map
`define FSPC_ADDR_CTRL       8'h00
`define FSPC_ADDR_LOCK       8'h04
`define FSPC_ADDR_STATUS     8'h08

// ==========================================================
// Control field positions
`define FSPC_BIT_INT_EN      7
`define FSPC_BIT_LIVE_BUSY   6
`define FSPC_BIT_SIG_ARM     5
`define FSPC_BIT_REENABLE    4
`define FSPC_BIT_LOCK_SET    3
`define FSPC_BIT_PAGE_WRITE  2
`define FSPC_BIT_PAGE_ERASE  1
`define FSPC_BIT_STORE_EN    0

// ==========================================================
// Accepted low five bit patterns
`define FSPC_PAT_REENABLE    5'h11
`define FSPC_PAT_LOCK_SET    5'h09
`define FSPC_PAT_PAGE_WRITE  5'h05
`define FSPC_PAT_PAGE_ERASE  5'h03
`define FSPC_PAT_BUF_LOAD    5'h01

// ==========================================================
// Reset values, windows and halting-section start page
`define FSPC_LOCK_RESET      6'h3f
`define FSPC_STORE_WINDOW    3'h4
`define FSPC_LOAD_WINDOW     3'h3
`define FSPC_HALTING_SECTION_PAGE       9'h1e0

// ==========================================================
// Timing
`define FSPC_CLK_NS          50
`define FSPC_OP_MIN_NS       3700000
`define FSPC_OP_MAX_NS       4500000

`endif

// File: design/fspc_ctrl.v
/*
 Self-programming control and lock logic of an on-chip program flash:
 control/status register, store/load instruction windows, page buffer
 fill, page erase and write timing, lock bits and protection decode.
 Assumes the CPU presents one-cycle store/load strobes with pointer and
 working registers valid, and that the flash array acts on the pulses.
*/
// Chosen here: the APB interface to the registers and the placing of the registers.
`include "fspc_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module fspc_ctrl #(
  parameter OP_CYCLES = (`FSPC_OP_MIN_NS + `FSPC_CLK_NS - 1) / `FSPC_CLK_NS
) (
  input  wire        clk,
  input  wire        rst,
  input  wire        ce,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // CPU side
  input  wire        storeStrobe,
  input  wire        loadStrobe,
  input  wire [16:0] pointer,
  input  wire [7:0]  workLo,
  input  wire [7:0]  workHi,
  input  wire        globalIntEnable,
  input  wire        execInBoot,
  input  wire        vectorsInBoot,
  input  wire [8:0]  bootStartPage,
  input  wire [7:0]  fuseByte,
  input  wire [7:0]  signatureByte,
  input  wire        chipErase,
  output reg         readyIrq,
  output reg         cpuStall,
  output reg         liveBlocked,
  output reg  [7:0]  loadData,
  output reg         loadValid,
  // Flash array side
  output reg         bufWrite,
  output reg  [6:0]  bufWordAddr,
  output reg  [15:0] bufData,
  output reg         bufClear,
  output reg         flashErase,
  output reg         flashWrite,
  output reg  [8:0]  flashPage,
  // Protection
  output reg  [5:0]  lockBits,
  output reg         extProgBlocked,
  output reg         extVerifyBlocked,
  output reg         fuseLocked,
  output reg         bootLockFrozen,
  output reg         appWriteLocked,
  output reg         appReadLocked,
  output reg         bootWriteLocked,
  output reg         bootReadLocked,
  output reg         intDisable
);

  // ==========================================================
  // Operation kinds
  localparam [1:0] OP_NONE  = 2'h0;
  localparam [1:0] OP_ERASE = 2'h1;
  localparam [1:0] OP_WRITE = 2'h2;
  localparam [1:0] OP_LOCK  = 2'h3;

  // ==========================================================
  // State
  reg        intEn;
  reg        liveBusy;
  reg        sigArm;
  reg        reenable;
  reg        lockSet;
  reg        pageWrite;
  reg        pageErase;
  reg        storeEn;
  reg [2:0]  armCnt;
  reg [1:0]  opKind;
  reg [31:0] opTimer;
  reg        opLive;
  reg        filling;
  reg [5:0]  pendLock;

  wire       apbDone  = psel & penable & pready;
  wire       apbWr    = apbDone & pwrite;
  wire       ctrlWr   = apbWr & (paddr == `FSPC_ADDR_CTRL);
  wire [4:0] wPat     = pwdata[4:0];
  wire       opBusy   = (opKind != OP_NONE);
  wire       storeOk  = storeStrobe & storeEn & (armCnt != 3'h0) & ~opBusy;
  wire       loadOk   = loadStrobe & storeEn & ~opBusy
                        & (armCnt > (`FSPC_STORE_WINDOW - `FSPC_LOAD_WINDOW));
  wire [8:0] ptrPage  = pointer[16:8];
  wire       ptrBoot  = (ptrPage >= bootStartPage);
  wire       ptrLive  = (ptrPage < `FSPC_HALTING_SECTION_PAGE);
  wire [7:0] ctrlVal  = {intEn, liveBusy, sigArm, reenable, lockSet, pageWrite, pageErase, storeEn};

  // Programmed lock bit reads zero; write lock is the low bit of a pair
  function wrDenied;
    input       boot;
    input [5:0] lb;
    begin
      wrDenied = boot ? ~lb[4] : ~lb[2];
    end
  endfunction

  function validPat;
    input [4:0] p;
    begin
      validPat = (p == `FSPC_PAT_REENABLE) | (p == `FSPC_PAT_LOCK_SET)
               | (p == `FSPC_PAT_PAGE_WRITE) | (p == `FSPC_PAT_PAGE_ERASE)
               | (p == `FSPC_PAT_BUF_LOAD);
    end
  endfunction

  // ==========================================================
  // APB slave: one wait state, answer registered
  always @(posedge clk) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else if (ce) begin
      pready  <= psel & penable & ~pready;
      pslverr <= 1'b0;
      if (psel & penable & ~pready) begin
        case (paddr)
          `FSPC_ADDR_CTRL:   prdata <= {24'h0, ctrlVal};
          `FSPC_ADDR_LOCK:   prdata <= {24'h0, 2'h3, lockBits};
          `FSPC_ADDR_STATUS: prdata <= {28'h0, filling, cpuStall, opKind};
          default: begin
            prdata  <= 32'h0;
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Control register, command windows and operations
  always @(posedge clk) begin
    if (rst) begin
      intEn      <= 1'b0;
      liveBusy   <= 1'b0;
      sigArm     <= 1'b0;
      reenable   <= 1'b0;
      lockSet    <= 1'b0;
      pageWrite  <= 1'b0;
      pageErase  <= 1'b0;
      storeEn    <= 1'b0;
      armCnt     <= 3'h0;
      opKind     <= OP_NONE;
      opTimer    <= 32'h0;
      opLive     <= 1'b0;
      filling    <= 1'b0;
      pendLock   <= `FSPC_LOCK_RESET;
      lockBits   <= `FSPC_LOCK_RESET;
      cpuStall   <= 1'b0;
      loadData   <= 8'h0;
      loadValid  <= 1'b0;
      bufWrite   <= 1'b0;
      bufWordAddr <= 7'h0;
      bufData    <= 16'h0;
      bufClear   <= 1'b0;
      flashErase <= 1'b0;
      flashWrite <= 1'b0;
      flashPage  <= 9'h0;
    end else if (ce) begin
      loadValid  <= 1'b0;
      bufWrite   <= 1'b0;
      bufClear   <= 1'b0;
      flashErase <= 1'b0;
      flashWrite <= 1'b0;

      if (opBusy) begin
        // Operation in flight: enable and command bit stay up
        if (opTimer == 32'h1) begin
          opKind    <= OP_NONE;
          storeEn   <= 1'b0;
          pageErase <= 1'b0;
          pageWrite <= 1'b0;
          lockSet   <= 1'b0;
          cpuStall  <= 1'b0;
          if (opKind == OP_LOCK)
            lockBits <= pendLock;
          if (opKind == OP_WRITE)
            filling <= 1'b0;
        end
        opTimer <= opTimer - 32'h1;
      end else if (storeOk) begin
        armCnt  <= 3'h0;
        storeEn <= 1'b0;
        sigArm  <= 1'b0;
        reenable <= 1'b0;
        if (sigArm) begin
          // Reserved signature mode: store does nothing
        end else if (reenable) begin
          liveBusy <= 1'b0;
        end else if (lockSet) begin
          pendLock <= lockBits & {workLo[5:2], 2'h3};
          opKind   <= OP_LOCK;
          opTimer  <= OP_CYCLES;
          storeEn  <= 1'b1;
        end else if (pageWrite | pageErase) begin
          if (wrDenied(ptrBoot, lockBits)) begin
            pageWrite <= 1'b0;
            pageErase <= 1'b0;
          end else begin
            opKind    <= pageWrite ? OP_WRITE : OP_ERASE;
            opTimer   <= OP_CYCLES;
            storeEn   <= 1'b1;
            flashPage <= ptrPage;
            flashWrite <= pageWrite;
            flashErase <= pageErase;
            liveBusy  <= ptrLive | liveBusy;
            cpuStall  <= ~ptrLive;
            opLive    <= ptrLive;
          end
        end else begin
          bufWrite    <= 1'b1;
          bufWordAddr <= pointer[7:1];
          bufData     <= {workHi, workLo};
          filling     <= 1'b1;
          liveBusy    <= 1'b0;
        end
      end else if (ctrlWr) begin
        intEn <= pwdata[`FSPC_BIT_INT_EN];
        if (validPat(wPat)) begin
          storeEn   <= 1'b1;
          armCnt    <= `FSPC_STORE_WINDOW;
          reenable  <= pwdata[`FSPC_BIT_REENABLE];
          lockSet   <= pwdata[`FSPC_BIT_LOCK_SET];
          pageWrite <= pwdata[`FSPC_BIT_PAGE_WRITE];
          pageErase <= pwdata[`FSPC_BIT_PAGE_ERASE];
          sigArm    <= pwdata[`FSPC_BIT_SIG_ARM] & (wPat == `FSPC_PAT_BUF_LOAD);
          if ((wPat == `FSPC_PAT_REENABLE) & filling) begin
            bufClear <= 1'b1;
            filling  <= 1'b0;
          end
        end
      end else if (loadOk & (sigArm | lockSet)) begin
        loadValid <= 1'b1;
        if (sigArm)
          loadData <= signatureByte;
        else if (pointer[0])
          loadData <= fuseByte;
        else
          loadData <= {2'h3, lockBits};
        armCnt  <= 3'h0;
        storeEn <= 1'b0;
        sigArm  <= 1'b0;
        lockSet <= 1'b0;
      end else if (storeEn & (armCnt != 3'h0)) begin
        armCnt <= armCnt - 3'h1;
        if (armCnt == 3'h1) begin
          storeEn   <= 1'b0;
          sigArm    <= 1'b0;
          reenable  <= 1'b0;
          lockSet   <= 1'b0;
          pageWrite <= 1'b0;
          pageErase <= 1'b0;
        end
      end else if (ctrlWr == 1'b0 && apbWr == 1'b0) begin
        armCnt <= armCnt;
      end

      // Interrupt-enable bit stays writable while a command runs
      if (opBusy & ctrlWr)
        intEn <= pwdata[`FSPC_BIT_INT_EN];

      // Chip erase is the only path back to unprogrammed lock bits
      if (chipErase & ~opBusy) begin
        lockBits <= `FSPC_LOCK_RESET;
        pendLock <= `FSPC_LOCK_RESET;
      end
    end
  end

  // ==========================================================
  // Registered status, interrupt and protection decode
  always @(posedge clk) begin
    if (rst) begin
      readyIrq         <= 1'b0;
      liveBlocked      <= 1'b0;
      extProgBlocked   <= 1'b0;
      extVerifyBlocked <= 1'b0;
      fuseLocked       <= 1'b0;
      bootLockFrozen   <= 1'b0;
      appWriteLocked   <= 1'b0;
      appReadLocked    <= 1'b0;
      bootWriteLocked  <= 1'b0;
      bootReadLocked   <= 1'b0;
      intDisable       <= 1'b0;
    end else if (ce) begin
      readyIrq         <= intEn & globalIntEnable & ~storeEn;
      liveBlocked      <= liveBusy;
      extProgBlocked   <= ~lockBits[0];
      fuseLocked       <= ~lockBits[0];
      extVerifyBlocked <= ~lockBits[0] & ~lockBits[1];
      bootLockFrozen   <= ~lockBits[0] & ~lockBits[1];
      appWriteLocked   <= ~lockBits[2];
      appReadLocked    <= ~lockBits[3] & execInBoot;
      bootWriteLocked  <= ~lockBits[4];
      bootReadLocked   <= ~lockBits[5] & ~execInBoot;
      intDisable       <= (~lockBits[3] & vectorsInBoot & ~execInBoot)
                        | (~lockBits[5] & ~vectorsInBoot & execInBoot);
    end
  end

endmodule // fspc_ctrl

`default_nettype wire

// File: verification/fspc_ctrl_checker.sv
/* Checker for fspc_ctrl: causes of erase and buffer-write pulses, stall span, lock decode.
   Assumes one clock with synchronous active-high reset. */
`timescale 1ns/1ps
`default_nettype none
module fspc_ctrl_checker #(
  parameter OP_CYCLES = 20
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [16:0] pointer,
  input wire logic        storeStrobe,
  input wire logic        loadStrobe,
  input wire logic        globalIntEnable,
  input wire logic        chipErase,
  input wire logic        readyIrq,
  input wire logic        cpuStall,
  input wire logic        loadValid,
  input wire logic        bufWrite,
  input wire logic [6:0]  bufWordAddr,
  input wire logic        flashErase,
  input wire logic        flashWrite,
  input wire logic [8:0]  flashPage,
  input wire logic [5:0]  lockBits,
  input wire logic        extProgBlocked,
  input wire logic        appWriteLocked,
  input wire logic        bootWriteLocked
);
  // ==========
  // Properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Stall span checked for 8 cycles only; OP_CYCLES is at least that in sim
  sequence s_halt_op;
    (flashErase || flashWrite) && flashPage >= 9'h1e0;
  endsequence
  a_irq_gate: assert property (!globalIntEnable |=> !readyIrq)
    else $error("ready request without global enable");
  a_stall_hold: assert property (s_halt_op |=> cpuStall [*8])
    else $error("stall dropped during halting operation");
  a_erase_src: assert property (flashErase |-> $past(storeStrobe))
    else $error("erase without store");
  a_buf_word: assert property (bufWrite |-> $past(storeStrobe) && bufWordAddr == $past(pointer[7:1]))
    else $error("buffer word wrong");
  a_load_src: assert property (loadValid |-> $past(loadStrobe))
    else $error("load answer without load");
  a_lock_sticky: assert property (!chipErase |=> (lockBits & ~$past(lockBits)) == 6'h00)
    else $error("lock bit returned to one");
  a_mem_lock: assert property ($past(lockBits[1:0]) != 2'b01 |-> extProgBlocked == !$past(lockBits[0]))
    else $error("memory lock decode wrong");
  a_sect_write: assert property (appWriteLocked == !$past(lockBits[2]) && bootWriteLocked == !$past(lockBits[4]))
    else $error("section write lock decode wrong");
endmodule // fspc_ctrl_checker

bind fspc_ctrl fspc_ctrl_checker #(.OP_CYCLES(OP_CYCLES)) u_chk (
  .clk(clk), .rst(rst), .pointer(pointer), .storeStrobe(storeStrobe), .loadStrobe(loadStrobe),
  .globalIntEnable(globalIntEnable), .chipErase(chipErase), .readyIrq(readyIrq), .cpuStall(cpuStall),
  .loadValid(loadValid), .bufWrite(bufWrite), .bufWordAddr(bufWordAddr), .flashErase(flashErase),
  .flashWrite(flashWrite), .flashPage(flashPage), .lockBits(lockBits), .extProgBlocked(extProgBlocked),
  .appWriteLocked(appWriteLocked), .bootWriteLocked(bootWriteLocked));
`default_nettype wire

// File: verification/fspc_cpu_model.sv
/* CPU core model: store/load strobes with pointer and working registers.
   Assumes each call starts right after a rising clk edge. */
`timescale 1ns/1ps
`default_nettype none
module fspc_cpu_model (
  output var logic        storeStrobe,
  output var logic        loadStrobe,
  output var logic [16:0] pointer,
  output var logic [7:0]  workLo,
  output var logic [7:0]  workHi,
  input wire logic        clk
);
  // ==========
  // Instruction issue
  initial begin
    storeStrobe = 1'b0;
    loadStrobe = 1'b0;
    pointer = 17'h0;
    {workHi, workLo} = 16'h0;
  end
  // One instruction at a time; caller waits for the previous one to end
  task automatic issue(input logic ld, input logic [16:0] p, input logic [15:0] w, input int g);
    repeat (g) @(posedge clk);
    pointer <= p;
    {workHi, workLo} <= w;
    loadStrobe <= ld;
    storeStrobe <= !ld;
    @(posedge clk);
    loadStrobe <= 1'b0;
    storeStrobe <= 1'b0;
    // Released operands toggle so a stale value never passes for a hold
    pointer <= ~p;
    {workHi, workLo} <= ~w;
  endtask
endmodule // fspc_cpu_model
`default_nettype wire

// File: verification/fspc_ctrl_test.sv
/* Testbench for fspc_ctrl: APB tasks, CPU model strobes, self-checks.
   Assumes 20 MHz clock and OP_CYCLES cut to 20. */
`timescale 1ns/1ps
`default_nettype none
module fspc_ctrl_test;
  logic        clk, rst, ce, psel, penable, pwrite, globalIntEnable, chipErase, execInBoot, vectorsInBoot;
  logic        pready, pslverr, e, readyIrq, cpuStall, loadValid, bufWrite, flashErase;
  logic        storeStrobe, loadStrobe, appWriteLocked, bootWriteLocked;
  logic        liveBlocked, bufClear, flashWrite, extProgBlocked, extVerifyBlocked, fuseLocked;
  logic        bootLockFrozen, appReadLocked, bootReadLocked, intDisable;
  logic [7:0]  paddr, fuseByte, signatureByte, loadData, workLo, workHi;
  logic [31:0] pwdata, prdata, q;
  logic [8:0]  bootStartPage, flashPage;
  logic [16:0] pointer;
  logic [6:0]  bufWordAddr;
  logic [15:0] bufData;
  logic [5:0]  lockBits;
  logic [7:0]  bad[4] = '{8'h87, 8'h9f, 8'h8b, 8'h93};
  logic [7:0]  cmds[5] = '{8'h91, 8'h89, 8'h85, 8'h83, 8'h81};
  int          errTotal = 0;
  int          checked = 0;
  fspc_ctrl #(.OP_CYCLES(20)) u_dut (
    .clk(clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .storeStrobe(storeStrobe),
    .loadStrobe(loadStrobe), .pointer(pointer), .workLo(workLo), .workHi(workHi),
    .globalIntEnable(globalIntEnable), .execInBoot(execInBoot), .vectorsInBoot(vectorsInBoot),
    .bootStartPage(bootStartPage), .fuseByte(fuseByte), .signatureByte(signatureByte),
    .chipErase(chipErase), .readyIrq(readyIrq), .cpuStall(cpuStall), .liveBlocked(liveBlocked),
    .loadData(loadData),
    .loadValid(loadValid), .bufWrite(bufWrite), .bufWordAddr(bufWordAddr), .bufData(bufData),
    .bufClear(bufClear), .flashErase(flashErase), .flashWrite(flashWrite), .flashPage(flashPage),
    .lockBits(lockBits), .extProgBlocked(extProgBlocked), .extVerifyBlocked(extVerifyBlocked),
    .fuseLocked(fuseLocked), .bootLockFrozen(bootLockFrozen), .appWriteLocked(appWriteLocked),
    .appReadLocked(appReadLocked), .bootWriteLocked(bootWriteLocked), .bootReadLocked(bootReadLocked),
    .intDisable(intDisable));
  fspc_cpu_model u_cpu (.clk(clk), .storeStrobe(storeStrobe), .loadStrobe(loadStrobe), .pointer(pointer),
    .workLo(workLo), .workHi(workHi));
  // ==========
  // Tasks
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] x);
    checked++;
    if (s !== x) begin
      errTotal++;
      $display("Error %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 40) errTotal++;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m = 32'hffffffff);
    apb(1'b0, a, 8'h00);
    check($sformatf("reg %h", a), q & m, x);
  endtask
  // Arm, then one instruction; returns one edge after it was taken
  task automatic op(input logic [7:0] c, input logic ld, input logic [16:0] p, input logic [15:0] w, input int g);
    apb(1'b1, 8'h00, c);
    u_cpu.issue(ld, p, w, g);
    @(posedge clk);
  endtask
  task automatic waitIdle();
    int n;
    n = 0;
    do begin
      apb(1'b0, 8'h00, 8'h00);
      n++;
    end while (q[0] !== 1'b0 && n < 50);
    if (n >= 50) errTotal++;
  endtask
  task automatic wrapUp();
    $display("Checks %0d errors %0d", checked, errTotal);
    if (errTotal == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ==========
  // Clock, watchdog, tests
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    errTotal++;
    wrapUp();
  end
  initial begin
    {rst, ce, globalIntEnable} = 3'b111;
    {psel, penable, pwrite, chipErase, execInBoot, vectorsInBoot} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    bootStartPage = 9'h1e0;
    fuseByte = 8'h5a;
    signatureByte = 8'ha7;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(8'h00, 32'h0);
    rd(8'h04, 32'hff);
    foreach (bad[i]) begin
      apb(1'b1, 8'h00, bad[i]);
      rd(8'h00, 32'h80);
    end
    check("irq", 32'(readyIrq), 32'h1);
    globalIntEnable <= 1'b0;
    repeat (2) @(posedge clk);
    check("irq", 32'(readyIrq), 32'h0);
    globalIntEnable <= 1'b1;
    foreach (cmds[i]) begin
      apb(1'b1, 8'h00, cmds[i]);
      repeat (6) @(posedge clk);
      rd(8'h00, 32'h80);
    end
    op(8'h83, 1'b0, {9'h010, 8'h00}, 16'h0, 0);
    check("erase", 32'({flashErase, flashPage}), 32'h210);
    rd(8'h00, 32'hc3);
    check("live blocked", 32'(liveBlocked), 32'h1);
    apb(1'b1, 8'h00, 8'h91);
    rd(8'h00, 32'hc3);
    check("irq", 32'(readyIrq), 32'h0);
    waitIdle();
    rd(8'h00, 32'hc0);
    op(8'h91, 1'b0, 17'h0, 16'h0, 0);
    rd(8'h00, 32'h80);
    check("live blocked", 32'(liveBlocked), 32'h0);
    op(8'h81, 1'b0, 17'h0000b, 16'hbeef, 3);
    check("fill", 32'({bufWrite, bufWordAddr, bufData}), 32'h85beef);
    rd(8'h08, 32'h8, 32'h8);
    rd(8'h00, 32'h80);
    op(8'h85, 1'b0, {9'h011, 8'h00}, 16'h0, 0);
    check("write", 32'({flashWrite, flashPage}), 32'h211);
    waitIdle();
    rd(8'h00, 32'hc0);
    op(8'h81, 1'b0, 17'h0, 16'h1234, 0);
    rd(8'h00, 32'h80);
    apb(1'b1, 8'h00, 8'h91);
    @(posedge clk);
    check("buf clear", 32'(bufClear), 32'h1);
    u_cpu.issue(1'b0, 17'h0, 16'h0, 0);
    @(posedge clk);
    rd(8'h08, 32'h0, 32'h8);
    op(8'h83, 1'b0, {9'h1e0, 8'h00}, 16'h0, 0);
    @(posedge clk);
    check("stall", 32'(cpuStall), 32'h1);
    waitIdle();
    repeat (2) @(posedge clk);
    check("stall", 32'(cpuStall), 32'h0);
    rd(8'h00, 32'h80);
    op(8'ha1, 1'b1, 17'h00002, 16'h0, 2);
    check("sig", 32'({loadValid, loadData}), 32'h1a7);
    op(8'ha1, 1'b0, 17'h0, 16'h1234, 0);
    check("sig store", 32'(bufWrite), 32'h0);
    // Application locks only; boot and memory locks stay unprogrammed
    op(8'h89, 1'b0, 17'h1ffff, 16'h55f3, 0);
    waitIdle();
    check("locks", 32'(lockBits), 32'h33);
    rd(8'h00, 32'h80);
    check("wr lock", 32'({appWriteLocked, bootWriteLocked}), 32'h2);
    execInBoot <= 1'b1;
    vectorsInBoot <= 1'b1;
    repeat (2) @(posedge clk);
    check("app rd lock", 32'({appReadLocked, intDisable}), 32'h2);
    execInBoot <= 1'b0;
    repeat (2) @(posedge clk);
    check("app rd lock", 32'({appReadLocked, intDisable}), 32'h1);
    check("mem lock", 32'({extProgBlocked, extVerifyBlocked, fuseLocked, bootLockFrozen, bootReadLocked}), 32'h0);
    apb(1'b1, 8'h04, 8'h00);
    rd(8'h04, 32'hf3);
    op(8'h89, 1'b1, 17'h0, 16'h0, 0);
    check("lock rd", 32'(loadData), 32'hf3);
    op(8'h89, 1'b1, 17'h1, 16'h0, 0);
    check("fuse rd", 32'(loadData), 32'h5a);
    chipErase <= 1'b1;
    @(posedge clk);
    chipErase <= 1'b0;
    repeat (2) @(posedge clk);
    check("locks", 32'(lockBits), 32'h3f);
    apb(1'b0, 8'h0c, 8'h00);
    check("slverr", {q[30:0], e}, 32'h1);
    wrapUp();
  end
endmodule // fspc_ctrl_test
`default_nettype wire
